//--- hdl/acccal_ctrl.sv
/*
 Converter core calibration controller: foreground and background calibration sequencing,
 core routing, swap delays and per-core trim registers.
 It assumes the register master obeys one-cycle strobes and that the trigger pin is asynchronous.
*/
// The implementer's own choice: the address-and-strobe port.
// Functional notes
// - Foreground calibration takes cores offline; outputs hold mid-code until done.
// - Background calibration keeps data flowing by substituting the spare core.
// - Foreground routing: A to core 0, B to 1, C to 4, D to 5.
// - Background: spare 2 replaces core 0 or 1; spare 3 replaces 4 or 5.
// - Calibration uses the internal reference, not the external input.
// - Foreground calibration runs after reset; host waits before configuring.
// - Trigger comes from pin or software bit per the source select bit.
// - In background one core per pair calibrates at a time; one spare active per pair.
// - Background rotation repeats forever, the spare standing in for each primary core of its pair in turn.
// - Offset, gain and termination trims load per-unit factory values at reset.
// - Trim values are readable and writable by software.
// - Trims are held separately per core and trim kind.
// - Foreground offset enable runs one buffer offset calibration in foreground.
// - Background offset enable keeps correcting offset in the rotation.
`timescale 1ns/1ps
`default_nettype none
module acccal_ctrl #(
   parameter int FG_CYC = acccal_pkg::FG_CAL_CYC,
   parameter int OFS_CYC = acccal_pkg::OFS_CAL_CYC,
   parameter int BG_CYC = acccal_pkg::BG_CORE_CYC,
   parameter logic [acccal_pkg::NUM_CORES*acccal_pkg::TRIM_KINDS*8-1:0] FACTORY_TRIM = '0
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [acccal_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [acccal_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [acccal_pkg::DATA_W-1:0] reg_rdata,
   input wire logic cal_trigger_pin,
   input wire logic [acccal_pkg::NUM_CORES*acccal_pkg::SAMPLE_W-1:0] core_sample,
   output logic [acccal_pkg::NUM_CHAN*acccal_pkg::SAMPLE_W-1:0] chan_sample,
   output logic [acccal_pkg::NUM_CORES-1:0] core_use_ref,
   output logic [acccal_pkg::NUM_CORES-1:0] core_cal_active,
   output logic buffer_ofs_cal,
   output logic [2:0] swap_core_ab,
   output logic [2:0] swap_core_cd,
   output logic [7:0] src_delay_out,
   output logic [7:0] mux_delay_out,
   output logic [acccal_pkg::NUM_CORES*acccal_pkg::TRIM_KINDS*8-1:0] trim_out
);
   localparam int SW = acccal_pkg::SAMPLE_W;
   localparam int NT = acccal_pkg::NUM_CORES * acccal_pkg::TRIM_KINDS;

   ////////////////////////////////////////////////////////////////////////////////
   logic [7:0] ctrl_ff;
   logic [7:0] src_dly_ff;
   logic [7:0] mux_dly_ff;
   logic [7:0] trim_ff [NT];
   logic [7:0] rdata_ff;
   logic trig_s1_ff;
   logic trig_s2_ff;
   logic trig_prev_ff;
   logic fg_done_ff;
   logic [31:0] cnt_ff;
   logic [2:0] cal_core_ff;
   logic [1:0] slot_ff;
   acccal_pkg::acccal_state_e state_ff;
   acccal_pkg::acccal_state_e nxt_state;
   logic [31:0] nxt_cnt;

   wire wr_ctrl = reg_wr && reg_addr == acccal_pkg::REG_CAL_CTRL;
   wire wr_src = reg_wr && reg_addr == acccal_pkg::REG_SRC_DLY;
   wire wr_mux = reg_wr && reg_addr == acccal_pkg::REG_MUX_DLY;
   wire [7:0] trim_idx = reg_addr - acccal_pkg::REG_TRIM_BASE;
   wire trim_hit = reg_addr >= acccal_pkg::REG_TRIM_BASE && trim_idx < 8'(NT);
   // The software bit or the synchronised pin, as the select bit chooses.
   wire trig_level = ctrl_ff[acccal_pkg::BIT_TRIG_SEL] ? trig_s2_ff
                     : ctrl_ff[acccal_pkg::BIT_SOFT_TRIG];
   wire trig_rise = trig_level && !trig_prev_ff;
   wire bg_mode = ctrl_ff[acccal_pkg::BIT_BG_EN] && !ctrl_ff[acccal_pkg::BIT_TRIG_SEL]
                  && ctrl_ff[acccal_pkg::BIT_SOFT_TRIG];
   wire fg_busy = state_ff == acccal_pkg::ACCCAL_FG || state_ff == acccal_pkg::ACCCAL_FG_OFS;
   wire cnt_end = cnt_ff == 32'h0;

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk)
   begin
      trig_s1_ff <= cal_trigger_pin;
      trig_s2_ff <= trig_s1_ff;
      trig_prev_ff <= sys_rst ? 1'h0 : trig_level;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ctrl_ff <= acccal_pkg::CTRL_RESET;
         src_dly_ff <= acccal_pkg::DLY_RESET;
         mux_dly_ff <= acccal_pkg::DLY_RESET;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_ff <= reg_wdata;
         if (wr_src)
            src_dly_ff <= reg_wdata;
         if (wr_mux)
            mux_dly_ff <= reg_wdata;
      end
   end

   // Trims reload factory values at reset and are otherwise software writable.
   genvar g;
   generate
      for (g = 0; g < NT; g++)
      begin : g_trim
         always_ff @(posedge clk)
         begin
            if (sys_rst)
               trim_ff[g] <= FACTORY_TRIM[g*8 +: 8];
            else if (reg_wr && trim_hit && trim_idx == 8'(g))
               trim_ff[g] <= reg_wdata;
         end
         assign trim_out[g*8 +: 8] = trim_ff[g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt = cnt_end ? 32'h0 : cnt_ff - 32'h1;
      case (state_ff)
         acccal_pkg::ACCCAL_FG:
            if (cnt_end)
            begin
               if (ctrl_ff[acccal_pkg::BIT_FG_OFS_EN])
               begin
                  nxt_state = acccal_pkg::ACCCAL_FG_OFS;
                  nxt_cnt = 32'(OFS_CYC - 1);
               end
               else
                  nxt_state = acccal_pkg::ACCCAL_IDLE;
            end
         acccal_pkg::ACCCAL_FG_OFS:
            if (cnt_end)
               nxt_state = acccal_pkg::ACCCAL_IDLE;
         acccal_pkg::ACCCAL_IDLE:
            if (bg_mode)
            begin
               nxt_state = acccal_pkg::ACCCAL_BG;
               nxt_cnt = 32'(BG_CYC - 1);
            end
            else if (trig_rise)
            begin
               nxt_state = acccal_pkg::ACCCAL_FG;
               nxt_cnt = 32'(FG_CYC - 1);
            end
         acccal_pkg::ACCCAL_BG:
            if (!bg_mode)
               nxt_state = acccal_pkg::ACCCAL_IDLE;
            else if (cnt_end)
               nxt_cnt = 32'(BG_CYC - 1);
         default:
            nxt_state = acccal_pkg::ACCCAL_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_ff <= acccal_pkg::ACCCAL_FG;
         cnt_ff <= 32'(FG_CYC - 1);
         fg_done_ff <= 1'h0;
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         // Done rises on the edge that ends the run, so no read sees neither busy nor done.
         if (fg_busy)
            fg_done_ff <= nxt_state == acccal_pkg::ACCCAL_IDLE;
      end
   end

   // Rotation slot: 0 and 1 calibrate the spares, 2 and 3 the cores they free.
   always_ff @(posedge clk)
   begin
      if (sys_rst || state_ff != acccal_pkg::ACCCAL_BG)
         slot_ff <= 2'h0;
      else if (cnt_end)
         slot_ff <= slot_ff + 2'h1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // In slots 2 and 3 the spare stands in for the primary core of each pair.
   wire in_bg = state_ff == acccal_pkg::ACCCAL_BG;
   wire sub_a = in_bg && slot_ff == 2'h2;
   wire sub_b = in_bg && slot_ff == 2'h3;
   assign swap_core_ab = sub_a ? acccal_pkg::CORE_A : sub_b ? acccal_pkg::CORE_B
                         : acccal_pkg::SPARE_AB;
   assign swap_core_cd = sub_a ? acccal_pkg::CORE_C : sub_b ? acccal_pkg::CORE_D
                         : acccal_pkg::SPARE_CD;
   wire [2:0] src_a = sub_a ? acccal_pkg::SPARE_AB : acccal_pkg::CORE_A;
   wire [2:0] src_b = sub_b ? acccal_pkg::SPARE_AB : acccal_pkg::CORE_B;
   wire [2:0] src_c = sub_a ? acccal_pkg::SPARE_CD : acccal_pkg::CORE_C;
   wire [2:0] src_d = sub_b ? acccal_pkg::SPARE_CD : acccal_pkg::CORE_D;
   wire [11:0] pick [4];
   assign pick[0] = core_sample[src_a*SW +: SW];
   assign pick[1] = core_sample[src_b*SW +: SW];
   assign pick[2] = core_sample[src_c*SW +: SW];
   assign pick[3] = core_sample[src_d*SW +: SW];

   logic [SW-1:0] out_ff [4];
   generate
      for (g = 0; g < 4; g++)
      begin : g_out
         always_ff @(posedge clk)
            out_ff[g] <= (sys_rst || fg_busy) ? acccal_pkg::MID_CODE : pick[g];
         assign chan_sample[g*SW +: SW] = out_ff[g];
      end
   endgenerate

   // One core per pair under calibration in background; all in foreground.
   wire [5:0] bg_cal = in_bg ? ((6'h01 << swap_core_ab) | (6'h01 << swap_core_cd))
                       : 6'h00;
   assign core_cal_active = fg_busy ? 6'h3F : bg_cal;
   assign core_use_ref = core_cal_active;
   assign buffer_ofs_cal = state_ff == acccal_pkg::ACCCAL_FG_OFS
                           || (in_bg && ctrl_ff[acccal_pkg::BIT_BG_OFS_EN]);
   assign src_delay_out = src_dly_ff;
   assign mux_delay_out = mux_dly_ff;

   ////////////////////////////////////////////////////////////////////////////////
   wire [7:0] stat = {5'h00, in_bg, fg_done_ff, fg_busy};
   wire [7:0] rd_mux = reg_addr == acccal_pkg::REG_CAL_CTRL ? ctrl_ff
                       : reg_addr == acccal_pkg::REG_CAL_STAT ? stat
                       : reg_addr == acccal_pkg::REG_SRC_DLY ? src_dly_ff
                       : reg_addr == acccal_pkg::REG_MUX_DLY ? mux_dly_ff
                       : trim_hit ? trim_ff[trim_idx[4:0]] : 8'h00;
   always_ff @(posedge clk)
      rdata_ff <= sys_rst ? 8'h00 : (reg_rd ? rd_mux : 8'h00);
   assign reg_rdata = rdata_ff;

   ////////////////////////////////////////////////////////////////////////////////
   chk_fg_mid_code: assert property (@(posedge clk) disable iff (sys_rst)
      fg_busy |=> chan_sample == '0)
      else $error("output not mid-code during foreground calibration");
   chk_rst_starts_fg: assert property (@(posedge clk)
      sys_rst |=> state_ff == acccal_pkg::ACCCAL_FG)
      else $error("reset did not start foreground calibration");
   chk_fg_routing: assert property (@(posedge clk) disable iff (sys_rst)
      !in_bg |=> chan_sample[SW +: SW] == $past(core_sample[SW +: SW]) || $past(fg_busy))
      else $error("channel B not routed from core 1");
   chk_one_core_pair: assert property (@(posedge clk) disable iff (sys_rst)
      in_bg |-> $countones(core_cal_active) == 2)
      else $error("more than one core per pair in calibration");
   chk_spare_sub: assert property (@(posedge clk) disable iff (sys_rst)
      sub_a |-> swap_core_ab == acccal_pkg::CORE_A && src_a == acccal_pkg::SPARE_AB)
      else $error("spare not substituted for core 0");
   chk_trig_start: assert property (@(posedge clk) disable iff (sys_rst)
      state_ff == acccal_pkg::ACCCAL_IDLE && !bg_mode && trig_rise
      |=> state_ff == acccal_pkg::ACCCAL_FG)
      else $error("trigger did not start foreground calibration");
   chk_src_delay_wr: assert property (@(posedge clk) disable iff (sys_rst)
      wr_src |=> src_delay_out == $past(reg_wdata))
      else $error("source delay write lost");
   chk_ofs_once: assert property (@(posedge clk) disable iff (sys_rst)
      state_ff == acccal_pkg::ACCCAL_FG_OFS && cnt_end |=> state_ff == acccal_pkg::ACCCAL_IDLE)
      else $error("foreground offset calibration did not finish");
   chk_status_busy: assert property (@(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == acccal_pkg::REG_CAL_STAT |=> reg_rdata[0] == $past(fg_busy))
      else $error("busy status wrong");
   cov_bg_rotate: cover property (@(posedge clk) disable iff (sys_rst) sub_a ##1 sub_b);
   cov_fg_ofs: cover property (@(posedge clk) disable iff (sys_rst)
      state_ff == acccal_pkg::ACCCAL_FG_OFS);
   cov_pin_trig: cover property (@(posedge clk) disable iff (sys_rst)
      trig_rise && ctrl_ff[acccal_pkg::BIT_TRIG_SEL]);
endmodule : acccal_ctrl
`default_nettype wire

//--- pkg/acccal_pkg.sv
/*
 Package for the converter core calibration controller.
 Holds the register map, field positions, reset values, core numbers and timing counts.
 It assumes a byte-addressed register port with 8-bit data.
*/
`default_nettype none
package acccal_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int NUM_CORES = 6;
   localparam int NUM_CHAN = 4;
   localparam int SAMPLE_W = 12;
   localparam int TRIM_W = 8;
   // Register offsets.
   localparam logic [7:0] REG_CAL_CTRL = 8'h80;
   localparam logic [7:0] REG_CAL_STAT = 8'h81;
   localparam logic [7:0] REG_SRC_DLY = 8'h9A;
   localparam logic [7:0] REG_MUX_DLY = 8'h9B;
   localparam logic [7:0] REG_TRIM_BASE = 8'hA0;
   localparam int TRIM_KINDS = 3;
   // Control register fields.
   localparam int BIT_SOFT_TRIG = 0;
   localparam int BIT_TRIG_SEL = 1;
   localparam int BIT_BG_EN = 2;
   localparam int BIT_FG_OFS_EN = 3;
   localparam int BIT_BG_OFS_EN = 4;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Status register fields.
   localparam int BIT_FG_BUSY = 0;
   localparam int BIT_FG_DONE = 1;
   localparam int BIT_BG_RUN = 2;
   localparam logic [7:0] DLY_RESET = 8'h00;
   localparam logic [SAMPLE_W-1:0] MID_CODE = 12'h000;
   // Core numbers.
   localparam logic [2:0] CORE_A = 3'h0;
   localparam logic [2:0] CORE_B = 3'h1;
   localparam logic [2:0] SPARE_AB = 3'h2;
   localparam logic [2:0] SPARE_CD = 3'h3;
   localparam logic [2:0] CORE_C = 3'h4;
   localparam logic [2:0] CORE_D = 3'h5;
   // Calibration step times in microseconds and the clock rate.
   localparam int CLK_MHZ = 20;
   localparam int FG_CAL_US = 100;
   localparam int FG_CAL_CYC = FG_CAL_US * CLK_MHZ;
   localparam int OFS_CAL_US = 20;
   localparam int OFS_CAL_CYC = OFS_CAL_US * CLK_MHZ;
   localparam int BG_CORE_US = 50;
   localparam int BG_CORE_CYC = BG_CORE_US * CLK_MHZ;
   typedef enum logic [1:0]
   {
      ACCCAL_IDLE = 2'b00,
      ACCCAL_FG = 2'b01,
      ACCCAL_FG_OFS = 2'b10,
      ACCCAL_BG = 2'b11
   } acccal_state_e;
endpackage : acccal_pkg
`default_nettype wire

//--- dv/tb_top.sv
/*
 Self-checking bench for the calibration controller: register port, triggers, foreground
 and background sequencing, channel routing, swap delays and trims.
 It assumes the controller package is compiled first and that the design's own assertions run.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
   begin \
      n_checks++; \
      if ((g) !== (e)) \
      begin \
         errors++; \
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
      end \
   end
module tb_top;
   localparam logic [143:0] FT = 144'h1112131415161718191A1B1C1D1E1F202122;
   // Core samples stand for converted data; the analog inputs carry nothing near DC.
   localparam logic [71:0] SAMP = 72'h6A55A44A33A22A11A0;
   logic clk = 1'h0;
   logic sys_rst = 1'h1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic cal_trigger_pin = 1'h0;
   logic [7:0] reg_rdata, src_delay_out, mux_delay_out, rv;
   logic [47:0] chan_sample;
   logic [5:0] core_use_ref, core_cal_active;
   logic [2:0] swap_core_ab, swap_core_cd, seen_ab, seen_cd;
   logic [143:0] trim_out;
   logic buffer_ofs_cal, bad, ofs_seen;
   int errors = 0;
   int n_checks = 0;
   int cycles = 0;
   acccal_ctrl #(.FG_CYC(8), .OFS_CYC(4), .BG_CYC(8), .FACTORY_TRIM(FT)) dut (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cal_trigger_pin(cal_trigger_pin), .core_sample(SAMP), .chan_sample(chan_sample),
      .core_use_ref(core_use_ref), .core_cal_active(core_cal_active),
      .buffer_ofs_cal(buffer_ofs_cal), .swap_core_ab(swap_core_ab),
      .swap_core_cd(swap_core_cd), .src_delay_out(src_delay_out),
      .mux_delay_out(mux_delay_out), .trim_out(trim_out));
   initial
   begin
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         errors++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("errors=%0d checks=%0d", errors, n_checks);
      if (errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1 d = reg_rdata;
   endtask : rd
   // Polls status until the foreground run ends, then checks that it is reported done.
   task automatic wait_idle();
      for (int i = 0; i < 60; i++)
      begin
         rd(8'h81, rv);
         if (rv[0] === 1'h0)
            break;
      end
      `CHK(rv[1:0], 2'h2)
   endtask : wait_idle
   task automatic fg_check();
      rd(8'h81, rv);
      `CHK(rv[0], 1'h1)
      `CHK(core_cal_active, 6'h3F)
      `CHK(core_use_ref, 6'h3F)
      `CHK(chan_sample, 48'h0)
      wait_idle();
   endtask : fg_check
   task automatic pin_pulse();
      @(posedge clk);
      cal_trigger_pin <= 1'h1;
      repeat (4) @(posedge clk);
      cal_trigger_pin <= 1'h0;
   endtask : pin_pulse
   ////////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'h0;
      fg_check();
      rd(8'h9A, rv);
      `CHK(rv, 8'h00)
      wr(8'h9A, 8'h1F);
      wr(8'h9B, 8'h1E);
      rd(8'h9A, rv);
      `CHK(rv, 8'h1F)
      rd(8'h9B, rv);
      `CHK(rv, 8'h1E)
      `CHK({src_delay_out, mux_delay_out}, 16'h1F1E)
      wr(8'h7F, 8'hFF);
      rd(8'h7F, rv);
      `CHK(rv, 8'h00)
      repeat (2) @(posedge clk);
      `CHK(chan_sample, 48'h6A55A42A11A0)
      for (int i = 0; i < 18; i++)
      begin
         rd(8'(8'hA0 + i), rv);
         `CHK(rv, FT[i*8+:8])
      end
      wr(8'hA5, 8'hC3);
      rd(8'hA5, rv);
      `CHK(rv, 8'hC3)
      `CHK(trim_out[47:32], {8'hC3, FT[39:32]})
      wr(8'h80, 8'h01);
      fg_check();
      wr(8'h80, 8'h00);
      wr(8'h80, 8'h02);
      wr(8'h80, 8'h03);
      repeat (4) @(posedge clk);
      rd(8'h81, rv);
      `CHK(rv[0], 1'h0)
      pin_pulse();
      fg_check();
      wr(8'h80, 8'h0A);
      ofs_seen = 1'h0;
      fork
         pin_pulse();
         for (int i = 0; i < 40; i++)
         begin
            @(posedge clk);
            #1 if (buffer_ofs_cal === 1'h1)
               ofs_seen = 1'h1;
         end
      join
      `CHK(ofs_seen, 1'h1)
      wait_idle();
      `CHK(buffer_ofs_cal, 1'h0)
      wr(8'h80, 8'h00);
      wr(8'h80, 8'h15);
      repeat (3) @(posedge clk);
      rd(8'h81, rv);
      `CHK({rv[2], rv[0]}, 2'h2)
      bad = 1'h0;
      ofs_seen = 1'h0;
      seen_ab = 3'h0;
      seen_cd = 3'h0;
      for (int i = 0; i < 120; i++)
      begin
         @(posedge clk);
         #1;
         if ($countones(core_cal_active[2:0]) != 1 || $countones(core_cal_active[5:3]) != 1)
            bad = 1'h1;
         if (core_use_ref !== core_cal_active)
            bad = 1'h1;
         if (!(chan_sample[11:0] inside {12'h1A0, 12'h3A2}))
            bad = 1'h1;
         if (!(chan_sample[23:12] inside {12'h2A1, 12'h3A2}))
            bad = 1'h1;
         if (!(chan_sample[35:24] inside {12'h5A4, 12'h4A3}))
            bad = 1'h1;
         if (!(chan_sample[47:36] inside {12'h6A5, 12'h4A3}))
            bad = 1'h1;
         if (swap_core_ab < 3'h3)
            seen_ab[swap_core_ab[1:0]] = 1'h1;
         if (swap_core_cd inside {3'h3, 3'h4, 3'h5})
            seen_cd[swap_core_cd - 3'h3] = 1'h1;
         if (buffer_ofs_cal === 1'h1)
            ofs_seen = 1'h1;
      end
      `CHK(bad, 1'h0)
      `CHK({seen_ab, seen_cd}, 6'h3F)
      `CHK(ofs_seen, 1'h1)
      wr(8'h80, 8'h00);
      summarize();
   end
endmodule : tb_top
`default_nettype wire
